// *** clk_sel_consts.vh ***
// constants for the system clock source select and internal oscillator control
// assumes inclusion by bare name from the design files of this block
`ifndef CLK_SEL_CONSTS_VH
`define CLK_SEL_CONSTS_VH

// ****************************************
// register offsets (index on the plain port)
// ****************************************
`define ADDR_OSC_CTRL       4'h0
`define ADDR_OSC_TUNE       4'h1
`define ADDR_TMR_CTRL       4'h2

// ****************************************
// field positions
// ****************************************
`define CTRL_IDLE_BIT       7
`define CTRL_FREQ_MSB       6
`define CTRL_FREQ_LSB       4
`define CTRL_STARTUP_BIT    3
`define CTRL_STABLE_BIT     2
`define CTRL_SEL_MSB        1
`define CTRL_SEL_LSB        0
`define TUNE_SRC_BIT        7
`define TUNE_VAL_MSB        5
`define TMR_RUN_BIT         6
`define TMR_EN_BIT          3

// ****************************************
// source and frequency codes
// ****************************************
`define SRC_PRIMARY         2'h0
`define SRC_SECONDARY       2'h1
`define SRC_INTERNAL        2'h2
`define FREQ_31K            3'h0
`define FREQ_8M             3'h7
`define FREQ_TOP_TAP        3'h6
`define DIV256_BIT          7

// ****************************************
// reset values
// ****************************************
`define RST_SYS_SEL         2'h0
`define RST_FREQ            3'h4
`define RST_BYTE            8'h00

// ****************************************
// switch pause counts
// ****************************************
`define OLD_FALLS           2'h2
`define NEW_RISES           2'h3

`endif

// *** pin_sync3.v ***
// three-stage synchroniser for asynchronous pin levels
// assumes one clock, synchronous active-high reset, clock enable freezing state
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter WIDTH = 6
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             ce_in,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // level taken once stages two and three agree
      always @(posedge clk_in) begin
        if (rst_in) begin
          s1_r[i]      <= 1'b0;
          s2_r[i]      <= 1'b0;
          s3_r[i]      <= 1'b0;
          level_out[i] <= 1'b0;
        end else if (ce_in) begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            level_out[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** glitch_free_switch.v ***
// glitch-free device clock switch among three sampled source levels
// assumes source levels already synchronised to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_consts.vh"
module glitch_free_switch (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  input  wire [2:0] src_lvl_in,
  input  wire [1:0] target_in,
  output reg        clk_out,
  output reg  [1:0] active_out,
  output reg        busy_out
);

  localparam ST_RUN = 2'h0;
  localparam ST_OLD = 2'h1;
  localparam ST_NEW = 2'h2;
  localparam ST_ARM = 2'h3;

  reg [1:0] state_r;
  reg [1:0] tgt_r;
  reg [1:0] cnt_r;
  reg [2:0] prev_r;

  // level of the source named by a select code
  function pick;
    input [1:0] code;
    input [2:0] lv;
    begin
      case (code)
        `SRC_PRIMARY:   pick = lv[0];
        `SRC_SECONDARY: pick = lv[1];
        default:        pick = lv[2];
      endcase
    end
  endfunction

  wire old_lvl  = pick(active_out, src_lvl_in);
  wire new_lvl  = pick(tgt_r, src_lvl_in);
  wire old_fall = pick(active_out, prev_r) & ~old_lvl;
  wire new_rise = ~pick(tgt_r, prev_r) & new_lvl;
  wire new_fall = pick(tgt_r, prev_r) & ~new_lvl;

  // old clock off on its falling edge, new one on after its edges
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r    <= ST_RUN;
      tgt_r      <= `SRC_PRIMARY;
      cnt_r      <= 2'h0;
      prev_r     <= 3'h0;
      clk_out    <= 1'b0;
      active_out <= `SRC_PRIMARY;
      busy_out   <= 1'b0;
    end else if (ce_in) begin
      prev_r <= src_lvl_in;
      case (state_r)
        ST_RUN: begin
          clk_out <= old_lvl;
          if (target_in != active_out) begin // RULE3
            tgt_r    <= target_in;
            cnt_r    <= 2'h0;
            busy_out <= 1'b1;
            state_r  <= ST_OLD;
          end
        end
        ST_OLD: begin
          clk_out <= old_lvl; // RULE18
          if (old_fall) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r + 2'h1 == `OLD_FALLS) begin // RULE17
              clk_out <= 1'b0;
              cnt_r   <= 2'h0;
              state_r <= ST_NEW;
            end
          end
        end
        ST_NEW: begin
          clk_out <= 1'b0;
          if (new_rise) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r + 2'h1 == `NEW_RISES) begin // RULE17
              state_r <= ST_ARM;
            end
          end
        end
        ST_ARM: begin
          clk_out <= 1'b0;
          if (new_fall) begin // RULE18
            active_out <= tgt_r;
            busy_out   <= 1'b0;
            state_r    <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** clk_source_select.v ***
// system clock source select and internal oscillator frequency control
// assumes a register master on REF_CLK_IN and oscillators arriving as raw pin levels
//
// Contract
// RULE1 - two-bit select field picks primary, secondary or internal block as device clock
// RULE2 - select field clears on every reset
// RULE3 - writing the select field starts a switch, finished after a short pause
// RULE4 - three-bit frequency field picks low-power RC, 8 MHz or 31 kHz-4 MHz postscaled
// RULE5 - internal block output follows frequency field writes at once
// RULE6 - reset sets internal block output to 1 MHz
// RULE7 - at code 000 source bit picks 8 MHz divided by 256 or low-power RC
// RULE8 - low-frequency source bit sits at bit 7 of tuning register
// RULE9 - watchdog and fail-safe monitor always run from low-power RC
// RULE10 - start-up done flag set once timer expired and primary clocks device
// RULE11 - internal stable flag set when internal block stable and clocking device; here also only at frequency codes other than 000
// RULE12 - secondary running flag, timer control bit 6, set while secondary clocks device
// RULE13 - at most one of the three source flags set at a time
// RULE14 - sleep instruction enters sleep if idle bit clear, idle if set
// RULE15 - secondary selection ignored at sleep time when secondary enable bit 3 clear
// RULE16 - software should have secondary oscillator stable before sleeping
// RULE17 - switch pauses clock two old cycles plus three to four new cycles
// RULE18 - switch gates old clock on falling edge before enabling new one
// RULE19 - select and frequency encodings are designer defined and handed over
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_consts.vh"
module clk_source_select (
  input  wire       REF_CLK_IN,
  input  wire       RST_IN,
  input  wire       CE_IN,
  input  wire [3:0] ADDR_IN,
  input  wire [7:0] WR_DATA_IN,
  input  wire       WR_STB_IN,
  input  wire       RD_STB_IN,
  output reg  [7:0] RD_DATA_OUT,
  input  wire       PRI_OSC_IN,
  input  wire       SEC_OSC_IN,
  input  wire       LPRC_OSC_IN,
  input  wire       FAST_OSC_IN,
  input  wire       OST_DONE_IN,
  input  wire       INT_OSC_READY_IN,
  input  wire       SLEEP_EXEC_IN,
  input  wire       WAKE_IN,
  output wire       SYS_CLK_OUT,
  output reg        WDT_CLK_OUT,
  output wire [1:0] ACTIVE_SRC_OUT,
  output wire       SWITCHING_OUT,
  output reg        SLEEP_MODE_OUT,
  output reg        IDLE_MODE_OUT
);

  // ****************************************
  // software visible state
  // ****************************************
  reg  [1:0] sys_clk_select_r;
  reg  [2:0] int_freq_select_r;
  reg        idle_on_sleep_r;
  reg        low_freq_src_select_r;
  reg  [5:0] tune_val_r;
  reg        secondary_osc_enable_r;
  reg        startup_done_flag_r;
  reg        int_osc_stable_flag_r;
  reg        secondary_running_flag_r;
  reg  [1:0] switch_target_r;

  // ****************************************
  // field encodings
  // ****************************************
  // select 00 primary, 01 secondary, 10 and 11 internal block // RULE19
  // frequency 111 fast oscillator, 110 down to 001 fast/2 to fast/64 // RULE19
  // frequency 000 fast/256 or low-power RC by the source bit // RULE19
  // frequency 100 after reset, fast/8 // RULE6
  // control: idle bit 7, frequency 6:4, flags 3:2, select 1:0
  // tuning: source bit 7, trim 5:0 held only
  // timer control: running flag 6, secondary enable 3
  // watchdog clock: low-power RC only // RULE9
  // switch: two old falls, three new rises, one new fall // RULE17

  // ****************************************
  // oscillator and status sampling
  // ****************************************
  wire [5:0] pins_s;
  wire       pri_s;
  wire       sec_s;
  wire       lprc_s;
  wire       fast_s;
  wire       ost_done_s;
  wire       int_ready_s;
  reg        fast_prev_r;
  reg  [7:0] div_r;
  wire       int_lvl;
  wire       sw_clk;
  wire [1:0] sw_active;
  wire       sw_busy;
  wire       refuse_sec;
  wire [1:0] target_eff;

  // strobe aimed at one register index
  function reg_hit;
    input       stb;
    input [3:0] addr;
    input [3:0] idx;
    begin
      reg_hit = stb & (addr == idx);
    end
  endfunction

  // write decode per register
  wire wr_ctrl = reg_hit(WR_STB_IN, ADDR_IN, `ADDR_OSC_CTRL);
  wire wr_tune = reg_hit(WR_STB_IN, ADDR_IN, `ADDR_OSC_TUNE);
  wire wr_tmr  = reg_hit(WR_STB_IN, ADDR_IN, `ADDR_TMR_CTRL);

  // all raw pins pass three stages
  pin_sync3 #(
    .WIDTH (6)
  ) u_sync (
    .clk_in    (REF_CLK_IN),
    .rst_in    (RST_IN),
    .ce_in     (CE_IN),
    .pin_in    ({INT_OSC_READY_IN, OST_DONE_IN, FAST_OSC_IN,
                 LPRC_OSC_IN, SEC_OSC_IN, PRI_OSC_IN}),
    .level_out (pins_s)
  );

  assign pri_s       = pins_s[0];
  assign sec_s       = pins_s[1];
  assign lprc_s      = pins_s[2];
  assign fast_s      = pins_s[3];
  assign ost_done_s  = pins_s[4];
  assign int_ready_s = pins_s[5];

  // ****************************************
  // internal oscillator block postscaler
  // ****************************************

  // ripple of the fast oscillator, one step per rising edge
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      fast_prev_r <= 1'b0;
      div_r       <= 8'h00;
    end else if (CE_IN) begin
      fast_prev_r <= fast_s;
      if (fast_s & ~fast_prev_r) begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // level of the internal block for a frequency code
  function freq_level;
    input [2:0] code;
    input [7:0] div;
    input       fast;
    input       lprc;
    input       src;
    reg   [2:0] tap;
    begin
      tap = `FREQ_TOP_TAP - code;
      if (code == `FREQ_8M) begin
        freq_level = fast;
      end else if (code == `FREQ_31K) begin
        freq_level = src ? div[`DIV256_BIT] : lprc;
      end else begin
        freq_level = div[tap];
      end
    end
  endfunction

  // output follows the field with no switch pause
  assign int_lvl = freq_level(int_freq_select_r, div_r, fast_s, lprc_s,
                              low_freq_src_select_r); // RULE4 RULE5 RULE7

  // ****************************************
  // glitch-free source switch
  // ****************************************

  // a secondary request is dropped at the sleep instruction while its oscillator is off
  assign refuse_sec = SLEEP_EXEC_IN & (sys_clk_select_r == `SRC_SECONDARY)
                      & ~secondary_osc_enable_r; // RULE15
  assign target_eff = refuse_sec ? sw_active : switch_target_r; // RULE15

  glitch_free_switch u_switch (
    .clk_in     (REF_CLK_IN),
    .rst_in     (RST_IN),
    .ce_in      (CE_IN),
    .src_lvl_in ({int_lvl, sec_s, pri_s}),
    .target_in  (target_eff),
    .clk_out    (sw_clk),
    .active_out (sw_active),
    .busy_out   (sw_busy)
  );

  assign SYS_CLK_OUT    = sw_clk;
  assign ACTIVE_SRC_OUT = sw_active;
  assign SWITCHING_OUT  = sw_busy;

  // ****************************************
  // control register writes
  // ****************************************

  // clock select, frequency select and idle choice
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      sys_clk_select_r  <= `RST_SYS_SEL; // RULE2
      int_freq_select_r <= `RST_FREQ; // RULE6
      idle_on_sleep_r   <= 1'b0;
    end else if (CE_IN) begin
      if (wr_ctrl) begin
        sys_clk_select_r  <= WR_DATA_IN[`CTRL_SEL_MSB:`CTRL_SEL_LSB]; // RULE1
        int_freq_select_r <= WR_DATA_IN[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB];
        idle_on_sleep_r   <= WR_DATA_IN[`CTRL_IDLE_BIT];
      end
    end
  end

  // tuning register: source bit plus stored trim
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      low_freq_src_select_r <= 1'b0;
      tune_val_r            <= 6'h00;
    end else if (CE_IN) begin
      if (wr_tune) begin
        low_freq_src_select_r <= WR_DATA_IN[`TUNE_SRC_BIT]; // RULE8
        tune_val_r            <= WR_DATA_IN[`TUNE_VAL_MSB:0];
      end
    end
  end

  // secondary oscillator enable
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      secondary_osc_enable_r <= 1'b0;
    end else if (CE_IN) begin
      if (wr_tmr) begin
        secondary_osc_enable_r <= WR_DATA_IN[`TMR_EN_BIT];
      end
    end
  end

  // ****************************************
  // switch target and sleep handling
  // ****************************************

  // target follows the field; a dead secondary is refused at sleep time
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      switch_target_r <= `SRC_PRIMARY;
    end else if (CE_IN) begin
      if (wr_ctrl) begin
        switch_target_r <= WR_DATA_IN[`CTRL_SEL_MSB:`CTRL_SEL_LSB]; // RULE3
      end else if (refuse_sec) begin
        switch_target_r <= sw_active; // RULE15
      end
    end
  end

  // sleep or idle chosen at the sleep instruction, left on wake
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      SLEEP_MODE_OUT <= 1'b0;
      IDLE_MODE_OUT  <= 1'b0;
    end else if (CE_IN) begin
      if (SLEEP_EXEC_IN & ~SLEEP_MODE_OUT & ~IDLE_MODE_OUT) begin
        SLEEP_MODE_OUT <= ~idle_on_sleep_r; // RULE14
        IDLE_MODE_OUT  <= idle_on_sleep_r; // RULE14
      end else if (WAKE_IN) begin
        SLEEP_MODE_OUT <= 1'b0;
        IDLE_MODE_OUT  <= 1'b0;
      end
    end
  end

  // ****************************************
  // source status flags
  // ****************************************

  wire       on_primary;
  wire       on_secondary;
  wire       on_internal;

  // source settled on one code, internal on 10 or 11, no switch under way
  assign on_primary   = ~sw_busy & (sw_active == `SRC_PRIMARY);
  assign on_secondary = ~sw_busy & (sw_active == `SRC_SECONDARY);
  assign on_internal  = ~sw_busy & sw_active[1];

  // one flag at most, none from one cycle after a switch starts to one cycle after it ends
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      startup_done_flag_r      <= 1'b0;
      int_osc_stable_flag_r    <= 1'b0;
      secondary_running_flag_r <= 1'b0;
    end else if (CE_IN) begin
      startup_done_flag_r      <= on_primary & ost_done_s; // RULE10 RULE13
      int_osc_stable_flag_r    <= on_internal & int_ready_s
                                  & (int_freq_select_r != `FREQ_31K); // RULE11 RULE13
      secondary_running_flag_r <= on_secondary; // RULE12 RULE13
    end
  end

  // ****************************************
  // watchdog clock
  // ****************************************

  // always the low-power RC, whatever the source bit says
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      WDT_CLK_OUT <= 1'b0;
    end else if (CE_IN) begin
      WDT_CLK_OUT <= lprc_s; // RULE9
    end
  end

  // ****************************************
  // register read port
  // ****************************************

  // data stand one cycle after the strobe, zero otherwise
  always @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      RD_DATA_OUT <= `RST_BYTE;
    end else if (CE_IN) begin
      RD_DATA_OUT <= `RST_BYTE;
      if (RD_STB_IN) begin
        case (ADDR_IN)
          `ADDR_OSC_CTRL: begin
            RD_DATA_OUT <= {idle_on_sleep_r, int_freq_select_r,
                            startup_done_flag_r, int_osc_stable_flag_r,
                            sys_clk_select_r};
          end
          `ADDR_OSC_TUNE: begin
            RD_DATA_OUT <= {low_freq_src_select_r, 1'b0, tune_val_r};
          end
          `ADDR_TMR_CTRL: begin
            RD_DATA_OUT <= {1'b0, secondary_running_flag_r, 2'b00,
                            secondary_osc_enable_r, 3'b000};
          end
          default: begin
            RD_DATA_OUT <= `RST_BYTE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** clk_source_select_assertions.sv ***
// checker for the clock source select block
// assumes binding to clk_source_select, one clock, RST_IN synchronous
`timescale 1ns/1ps
`default_nettype none
module clk_source_select_assertions (
  input wire logic       REF_CLK_IN,
  input wire logic       RST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic       WR_STB_IN,
  input wire logic       RD_STB_IN,
  input wire logic [7:0] RD_DATA_OUT,
  input wire logic       LPRC_OSC_IN,
  input wire logic       SLEEP_EXEC_IN,
  input wire logic       WAKE_IN,
  input wire logic       SYS_CLK_OUT,
  input wire logic       WDT_CLK_OUT,
  input wire logic [1:0] ACTIVE_SRC_OUT,
  input wire logic       SWITCHING_OUT,
  input wire logic       SLEEP_MODE_OUT,
  input wire logic       IDLE_MODE_OUT
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_reset_outputs: assert property (
    $fell(RST_IN) |-> ACTIVE_SRC_OUT == 2'h0 && !SWITCHING_OUT && !SLEEP_MODE_OUT)
    else $error("outputs not cleared by reset");
  a_rd_unmapped: assert property (
    RD_STB_IN && ADDR_IN > 4'h2 |=> RD_DATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_switch_start: assert property (
    (WR_STB_IN && ADDR_IN == 4'h0 && WR_DATA_IN[1:0] != ACTIVE_SRC_OUT
     && WR_DATA_IN[1:0] != 2'h3 && !SWITCHING_OUT) ##1 !SLEEP_EXEC_IN
    |-> ##1 SWITCHING_OUT)
    else $error("switch did not start");
  a_switch_bounded: assert property (
    $rose(SWITCHING_OUT) |-> ##[1:300] !SWITCHING_OUT)
    else $error("switch pause too long");
  a_active_moves: assert property (
    $changed(ACTIVE_SRC_OUT) |-> $fell(SWITCHING_OUT))
    else $error("source changed outside switch end");
  a_clock_paused: assert property (
    $fell(SWITCHING_OUT) |-> $past(SYS_CLK_OUT) == 1'b0)
    else $error("device clock not held low at switch end");
  a_sleep_entry: assert property (
    SLEEP_EXEC_IN && !SLEEP_MODE_OUT && !IDLE_MODE_OUT && !WAKE_IN
    |=> SLEEP_MODE_OUT ^ IDLE_MODE_OUT)
    else $error("sleep instruction gave no single mode");
  a_wdt_source: assert property (
    $rose(WDT_CLK_OUT) |-> $past(LPRC_OSC_IN, 4))
    else $error("watchdog clock not from rc source");
  a_flag_pair: assert property (
    RD_STB_IN && ADDR_IN == 4'h0 |=> !(RD_DATA_OUT[3] && RD_DATA_OUT[2]))
    else $error("two source flags set");
  a_sec_flag: assert property (
    RD_STB_IN && ADDR_IN == 4'h2 && ACTIVE_SRC_OUT == 2'h1 && !SWITCHING_OUT
    && !$past(SWITCHING_OUT) && !$past(SWITCHING_OUT, 2) |=> RD_DATA_OUT[6])
    else $error("secondary flag missing");

  c_to_internal: cover property ($fell(SWITCHING_OUT) && ACTIVE_SRC_OUT == 2'h2);
  c_to_secondary: cover property ($fell(SWITCHING_OUT) && ACTIVE_SRC_OUT == 2'h1);
  c_idle: cover property ($rose(IDLE_MODE_OUT));
endmodule

bind clk_source_select clk_source_select_assertions chk_u (.REF_CLK_IN, .RST_IN,
  .ADDR_IN, .WR_DATA_IN, .WR_STB_IN, .RD_STB_IN, .RD_DATA_OUT, .LPRC_OSC_IN,
  .SLEEP_EXEC_IN, .WAKE_IN, .SYS_CLK_OUT, .WDT_CLK_OUT, .ACTIVE_SRC_OUT,
  .SWITCHING_OUT, .SLEEP_MODE_OUT, .IDLE_MODE_OUT);
`default_nettype wire

// *** clk_source_select_bench.sv ***
// testbench for the clock source select block
// assumes design and checker compiled first; oscillators made here
`timescale 1ns/1ps
`default_nettype none
module clk_source_select_bench;
  // ****************************************
  // signals and oscillators
  // ****************************************
  logic       clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic       pri = 1'b0, sec = 1'b0, lprc = 1'b0, fast = 1'b0;
  logic       osc_startup_timer = 1'b0, slp = 1'b0, wake = 1'b0, rdy = 1'b1;
  logic       sys_clk, wdt_clk, busy, sleep_m, idle_m;
  logic [1:0] active;
  int         tick = 0, c, cw, num_errors = 0, cmp_count = 0;

  initial forever #20 clk = ~clk;

  // free running sources, half periods 4, 5, 6 and 3 cycles
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick % 4 == 0)
      pri <= ~pri;
    if (tick % 5 == 0)
      sec <= ~sec;
    if (tick % 6 == 0)
      lprc <= ~lprc;
    if (tick % 3 == 0)
      fast <= ~fast;
  end

  clk_source_select dut_u (
    .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_STB_IN(wr_stb), .RD_STB_IN(rd_stb),
    .RD_DATA_OUT(rdata), .PRI_OSC_IN(pri), .SEC_OSC_IN(sec),
    .LPRC_OSC_IN(lprc), .FAST_OSC_IN(fast), .OST_DONE_IN(osc_startup_timer),
    .INT_OSC_READY_IN(rdy), .SLEEP_EXEC_IN(slp), .WAKE_IN(wake),
    .SYS_CLK_OUT(sys_clk), .WDT_CLK_OUT(wdt_clk), .ACTIVE_SRC_OUT(active),
    .SWITCHING_OUT(busy), .SLEEP_MODE_OUT(sleep_m), .IDLE_MODE_OUT(idle_m));

  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report;
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    check(rdata, e);
  endtask

  // bounded wait for the switch flag to reach a level
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        num_errors++;
        final_report();
      end
    end
  endtask

  task automatic switch_to(input logic [7:0] ctl, input logic [1:0] src);
    wr(4'h0, ctl);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 300);
    check(active, src);
  endtask

  // device and watchdog clock toggles over 60 cycles
  task automatic count_toggles(output int t, output int w);
    logic last, lastw;
    t = 0;
    w = 0;
    last = sys_clk;
    lastw = wdt_clk;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (sys_clk !== last)
        t++;
      if (wdt_clk !== lastw)
        w++;
      last = sys_clk;
      lastw = wdt_clk;
    end
  endtask

  // control write, sleep instruction next cycle, then wake
  task automatic nap(input logic [7:0] ctl, input logic [1:0] e);
    wr(4'h0, ctl);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    #1;
    check({sleep_m, idle_m}, e);
    check(busy, 1'b0);
    repeat (100) @(posedge clk);
    check(active, 2'h0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
    check({sleep_m, idle_m}, 2'b00);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h40);
    rd(4'h2, 8'h00);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    wr(4'h1, 8'hbf);
    rd(4'h1, 8'hbf);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h08);
    for (int f = 0; f < 8; f++) begin
      wr(4'h0, {1'b0, 3'(f), 4'hc});
      rd(4'h0, {1'b0, 3'(f), 4'h0});
    end
    @(posedge clk);
    osc_startup_timer <= 1'b1;
    repeat (8) @(posedge clk);
    rd(4'h0, 8'h78);
    switch_to(8'h72, 2'h2);
    rd(4'h0, 8'h76);
    @(posedge clk);
    rdy <= 1'b0;
    repeat (6) @(posedge clk);
    rd(4'h0, 8'h72);
    @(posedge clk);
    rdy <= 1'b1;
    count_toggles(c, cw);
    check(c >= 16, 1'b1);
    wr(4'h0, 8'h02);
    repeat (10) @(posedge clk);
    rd(4'h0, 8'h02);
    count_toggles(c, cw);
    check(c <= 1, 1'b1);
    check(cw >= 8 && cw <= 12, 1'b1);
    wr(4'h1, 8'h00);
    repeat (10) @(posedge clk);
    count_toggles(c, cw);
    check(c >= 8 && c <= 12, 1'b1);
    wr(4'h2, 8'h08);
    switch_to(8'h01, 2'h1);
    rd(4'h2, 8'h48);
    switch_to(8'h00, 2'h0);
    repeat (8) @(posedge clk);
    rd(4'h0, 8'h08);
    nap(8'h00, 2'b10);
    nap(8'h80, 2'b01);
    wr(4'h2, 8'h00);
    nap(8'h01, 2'b10);
    @(posedge clk);
    rst <= 1'b1;
    osc_startup_timer <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h40);
    check(active, 2'h0);
    final_report();
  end
endmodule
`default_nettype wire
